/* File: ubg_pkg.sv */
package ubg_pkg;
	// Register byte offsets
	localparam logic [7:0] UBG_OFS_CTL1   = 8'h00;
	localparam logic [7:0] UBG_OFS_PRE_LO = 8'h04;
	localparam logic [7:0] UBG_OFS_PRE_HI = 8'h08;
	localparam logic [7:0] UBG_OFS_MOD    = 8'h0c;
	localparam logic [7:0] UBG_OFS_STAT   = 8'h10;
	// Reset values
	localparam logic [7:0] UBG_CTL1_RST   = 8'h01;
	localparam logic [7:0] UBG_BYTE_RST   = 8'h00;
	// Field positions
	localparam int UBG_CTL1_SWRST = 0;
	localparam int UBG_CTL1_SEL_LO = 6;
	localparam int UBG_MOD_OS16   = 0;
	localparam int UBG_MOD_BRS_LO = 1;
	localparam int UBG_MOD_BRF_LO = 4;
	localparam int UBG_STAT_RUN   = 0;
	// Source select codes
	localparam logic [1:0] UBG_SRC_PIN = 2'h0;
	localparam logic [1:0] UBG_SRC_AUX = 2'h1;
	// Timing counts
	localparam logic [3:0] UBG_OS_LAST  = 4'hf;
	localparam logic [2:0] UBG_BIT_LAST = 3'h7;
	typedef enum logic [1:0] {
		UBG_ST_HOLD = 2'b01,
		UBG_ST_RUN  = 2'b10
	} ubg_state_e;
endpackage

/* File: ubg_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ubg_top (
	// System
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Source clocks
	input  wire logic        ext_clk_i,
	input  wire logic        aux_tick_i,
	// Generated ticks
	output logic             os_tick_o,
	output logic             bit_tick_o
);
	import ubg_pkg::*;

	// Register state
	logic [7:0]  ctl1_q, ctl1_d;
	logic [7:0]  pre_lo_q, pre_lo_d;
	logic [7:0]  pre_hi_q, pre_hi_d;
	logic [7:0]  mod_q, mod_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	// Pin synchroniser
	logic [2:0]  sync_q, sync_d;
	logic        pin_q, pin_d;
	// Generator state
	ubg_state_e  st_q, st_d;
	logic [16:0] cnt_q, cnt_d;
	logic [3:0]  os_idx_q, os_idx_d;
	logic [2:0]  bit_idx_q, bit_idx_d;
	logic        os_tick_q, os_tick_d;
	logic        bit_tick_q, bit_tick_d;
	// Decode
	logic        req;
	logic [15:0] presc;
	logic        os16;
	logic [3:0]  brf;
	logic [2:0]  brs;
	logic        src_tick;
	logic        ext_f;
	logic        ext_s;
	logic [16:0] limit;

	function automatic logic [7:0] wr_byte(input logic [7:0] old,
			input logic [31:0] d, input logic lane);
		wr_byte = lane ? d[7:0] : old;
	endfunction

	assign req = cyc_i && stb_i && !ack_q;
	assign presc = {pre_hi_q, pre_lo_q};
	assign os16 = mod_q[UBG_MOD_OS16];
	assign brf = mod_q[UBG_MOD_BRF_LO +: 4];
	assign brs = mod_q[UBG_MOD_BRS_LO +: 3];

	// Register file
	always_comb begin
		ctl1_d = ctl1_q;
		pre_lo_d = pre_lo_q;
		pre_hi_d = pre_hi_q;
		mod_d = mod_q;
		ack_d = req;
		rdat_d = rdat_q;
		if (req && we_i) begin
			case (adr_i)
				UBG_OFS_CTL1: ctl1_d = wr_byte(ctl1_q, dat_i, sel_i[0]);
				UBG_OFS_PRE_LO: pre_lo_d = wr_byte(pre_lo_q, dat_i, sel_i[0]);
				UBG_OFS_PRE_HI: pre_hi_d = wr_byte(pre_hi_q, dat_i, sel_i[0]);
				UBG_OFS_MOD: mod_d = wr_byte(mod_q, dat_i, sel_i[0]);
				default: ;
			endcase
		end
		if (req && !we_i) begin
			case (adr_i)
				UBG_OFS_CTL1: rdat_d = {24'h000000, ctl1_q};
				UBG_OFS_PRE_LO: rdat_d = {24'h000000, pre_lo_q};
				UBG_OFS_PRE_HI: rdat_d = {24'h000000, pre_hi_q};
				UBG_OFS_MOD: rdat_d = {24'h000000, mod_q};
				UBG_OFS_STAT: rdat_d = {31'h00000000,
					st_q == UBG_ST_RUN};
				default: rdat_d = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctl1_q <= UBG_CTL1_RST;
			pre_lo_q <= UBG_BYTE_RST;
			pre_hi_q <= UBG_BYTE_RST;
			mod_q <= UBG_BYTE_RST;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ctl1_q <= ctl1_d;
			pre_lo_q <= pre_lo_d;
			pre_hi_q <= pre_hi_d;
			mod_q <= mod_d;
			ack_q <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	assign ack_o = ack_q;
	assign dat_o = rdat_q;

	// Pin source filter
	always_comb begin
		sync_d = {sync_q[1:0], ext_clk_i};
		pin_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : pin_q;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_q <= 3'h0;
			pin_q <= 1'b0;
		end else begin
			sync_q <= sync_d;
			pin_q <= pin_d;
		end
	end

	// Source tick select
	always_comb begin
		case (ctl1_q[UBG_CTL1_SEL_LO +: 2])
			UBG_SRC_PIN: src_tick = pin_d && !pin_q;
			UBG_SRC_AUX: src_tick = aux_tick_i;
			default: src_tick = 1'b1;
		endcase
	end

	// Modulation extras
	assign ext_f = os16 && (os_idx_q < brf);
	assign ext_s = (bit_idx_q < brs) &&
		(!os16 || os_idx_q == UBG_OS_LAST);
	assign limit = {1'b0, presc} + {16'h0000, ext_f} + {16'h0000, ext_s}
		- 17'h00001;

	// Divider
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		os_idx_d = os_idx_q;
		bit_idx_d = bit_idx_q;
		os_tick_d = 1'b0;
		bit_tick_d = 1'b0;
		case (st_q)
			UBG_ST_HOLD: begin
				cnt_d = 17'h00000;
				os_idx_d = 4'h0;
				bit_idx_d = 3'h0;
				if (!ctl1_q[UBG_CTL1_SWRST]) begin
					st_d = UBG_ST_RUN;
				end
			end
			UBG_ST_RUN: begin
				if (ctl1_q[UBG_CTL1_SWRST]) begin
					st_d = UBG_ST_HOLD;
				end else if (src_tick) begin
					// Zero prescaler ticks on every source tick and ignores the extras, no underflow
					if (cnt_q >= limit || presc == 16'h0000) begin
						cnt_d = 17'h00000;
						if (os16) begin
							os_tick_d = 1'b1;
							os_idx_d = os_idx_q + 4'h1;
							if (os_idx_q == UBG_OS_LAST) begin
								bit_tick_d = 1'b1;
								bit_idx_d = bit_idx_q + 3'h1;
							end
						end else begin
							os_idx_d = 4'h0;
							bit_tick_d = 1'b1;
							bit_idx_d = bit_idx_q + 3'h1;
						end
					end else begin
						cnt_d = cnt_q + 17'h00001;
					end
				end
			end
			default: st_d = UBG_ST_HOLD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= UBG_ST_HOLD;
			cnt_q <= 17'h00000;
			os_idx_q <= 4'h0;
			bit_idx_q <= 3'h0;
			os_tick_q <= 1'b0;
			bit_tick_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			os_idx_q <= os_idx_d;
			bit_idx_q <= bit_idx_d;
			os_tick_q <= os_tick_d;
			bit_tick_q <= bit_tick_d;
		end
	end

	assign os_tick_o = os_tick_q;
	assign bit_tick_o = bit_tick_q;

	// Checks
	presc_value_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		ack_q && $past(we_i) && $past(adr_i) == UBG_OFS_PRE_HI
		&& $past(sel_i[0]) |-> presc[15:8] == $past(dat_i[7:0]))
		else $error("high prescaler byte not taken");
	brf_extra_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		os16 && os_tick_d && !ext_s && presc != 16'h0000 |->
		cnt_q == {1'b0, presc} - 17'h00001 + {16'h0000, os_idx_q < brf})
		else $error("first stage extra missing");
	brf_ignored_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!os16 && bit_tick_d && bit_idx_q >= brs && presc != 16'h0000
		|-> cnt_q == {1'b0, presc} - 17'h00001)
		else $error("first stage active without oversampling");
	brs_extra_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		!os16 && bit_idx_q < brs |-> limit == {1'b0, presc})
		else $error("second stage extra wrong");
	os_enable_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		os_tick_q |-> $past(mod_q[UBG_MOD_OS16]))
		else $error("oversampled tick while disabled");
	os_sixteen_a: assert property (@(posedge clk_i)
		disable iff (rst_i)
		os16 && bit_tick_q |-> os_tick_q && os_idx_q == 4'h0)
		else $error("bit tick not on sixteenth tick");
	soft_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ctl1_q[UBG_CTL1_SWRST] ##1 ctl1_q[UBG_CTL1_SWRST] |->
		##1 !bit_tick_q && !os_tick_q)
		else $error("ticks during soft reset");
	wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
		cyc_i && stb_i && !ack_q |=> ack_q ##1 !ack_q)
		else $error("ack not one cycle");
endmodule
`default_nettype wire

/* File: ubg_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ubg_link_model (
	// Ticks from the generator
	input  wire logic        clk_i,
	input  wire logic        os_tick_i,
	input  wire logic        bit_tick_i,
	// Measured bit timing
	output logic      [31:0] period_o,
	output logic      [7:0]  os_cnt_o
);
	logic [31:0] cnt_q = 32'h0;
	logic [7:0]  os_q = 8'h0;
	// Cycles and oversampled ticks per bit period
	always_ff @(posedge clk_i) begin
		cnt_q <= bit_tick_i ? 32'h1 : cnt_q + 32'h1;
		os_q  <= bit_tick_i ? 8'h0 : os_q + {7'h0, os_tick_i};
		if (bit_tick_i) begin
			period_o <= cnt_q;
			os_cnt_o <= os_q + {7'h0, os_tick_i};
		end
	end
endmodule
`default_nettype wire

/* File: ubg_top_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ubg_top_tb_top;
	import ubg_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc_i = 1'b0;
	logic        stb_i = 1'b0;
	logic        we_i  = 1'b0;
	logic [7:0]  adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        os_tick_o;
	logic        bit_tick_o;
	logic [31:0] per;
	logic [7:0]  os_cnt;
	logic [7:0]  rdat;
	logic [31:0] span;
	logic [3:0]  sel_i = 4'h1;
	logic [3:0]  sel_v = 4'h1;
	logic [1:0]  src_div_q = 2'h0;
	integer      err_total = 0;
	integer      tests_run = 0;
	ubg_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.ext_clk_i(src_div_q[1]), .aux_tick_i(src_div_q[0]),
		.os_tick_o(os_tick_o), .bit_tick_o(bit_tick_o));
	ubg_link_model u_link (.clk_i(clk_i), .os_tick_i(os_tick_o),
		.bit_tick_i(bit_tick_o), .period_o(per), .os_cnt_o(os_cnt));
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	// Pin clock of four cycles and auxiliary tick every other cycle
	always @(posedge clk_i) begin
		src_div_q <= src_div_q + 2'h1;
	end
	task automatic chk(input string nm, input logic [31:0] e, a);
		tests_run++;
		if (a !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, e, a);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		sel_i <= sel_v;
		adr_i <= a;
		dat_i <= {24'h0, d};
		do begin
			@(posedge clk_i);
		end while (ack_o !== 1'b1);
		rdat = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	task automatic meas();
		integer i;
		span = 32'h0;
		for (i = 0; i < 9; i++) begin
			do begin
				@(posedge clk_i);
			end while (bit_tick_o !== 1'b1);
			#1;
			if (i > 0) span = span + per;
		end
	endtask
	task automatic run(input logic [7:0] lo, hi, md, sc,
			input logic [31:0] e);
		wb(1'b1, UBG_OFS_CTL1, sc | 8'h01);
		wb(1'b1, UBG_OFS_PRE_LO, lo);
		wb(1'b1, UBG_OFS_PRE_HI, hi);
		wb(1'b1, UBG_OFS_MOD, md);
		wb(1'b1, UBG_OFS_CTL1, sc);
		meas();
		chk("eight_bit_span", e, span);
		if (md[0]) chk("os_per_bit", 32'd16, {24'h0, os_cnt});
		wb(1'b0, UBG_OFS_STAT, 8'h00);
		chk("running", 32'h01, {24'h0, rdat});
		$display("test done lo=%h hi=%h mod=%h src=%h", lo, hi, md, sc);
	endtask
	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		report_and_stop();
	end
	initial begin
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, UBG_OFS_CTL1, 8'h00);
		chk("ctl1_reset", 32'h01, {24'h0, rdat});
		wb(1'b0, UBG_OFS_MOD, 8'h00);
		chk("mod_reset", 32'h00, {24'h0, rdat});
		wb(1'b1, UBG_OFS_PRE_HI, 8'ha5);
		wb(1'b0, UBG_OFS_PRE_HI, 8'h00);
		chk("pre_hi_rw", 32'ha5, {24'h0, rdat});
		sel_v = 4'h0;
		wb(1'b1, UBG_OFS_PRE_LO, 8'h3c);
		sel_v = 4'h1;
		wb(1'b0, UBG_OFS_PRE_LO, 8'h00);
		chk("pre_lo_lane_off", 32'h00, {24'h0, rdat});
		wb(1'b0, 8'h14, 8'h00);
		chk("unmapped", 32'h00, {24'h0, rdat});
		$display("test done registers");
		run(8'h05, 8'h00, 8'h00, 8'h80, 32'd40);
		run(8'h02, 8'h01, 8'h00, 8'h80, 32'd2064);
		run(8'h05, 8'h00, 8'hf0, 8'h80, 32'd40);
		run(8'h05, 8'h00, 8'h06, 8'h80, 32'd43);
		run(8'h02, 8'h00, 8'h01, 8'h80, 32'd256);
		run(8'h02, 8'h00, 8'h21, 8'h80, 32'd272);
		run(8'h05, 8'h00, 8'h00, 8'h40, 32'd80);
		run(8'h03, 8'h00, 8'h00, 8'h00, 32'd96);
		report_and_stop();
	end
endmodule
`default_nettype wire
